// ---- position_report_formatter_tb.sv ----
// testbench for the position report formatter
module position_report_formatter_tb;
  import prf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, sys_rst, req_valid, req_ready, slow, tx_valid, tx_ready;
  prf_req_t    req;
  logic [3:0]  unit_number;
  logic [31:0] move_steps;
  logic [15:0] seq_checksum;
  logic [7:0]  tx_data;
  logic [7:0]  e[$];
  int          miscompares, cmp_count;
  prf_formatter u_prf_formatter (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .unit_number(unit_number),
    .move_steps(move_steps), .seq_checksum(seq_checksum), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  prf_host u_prf_host (.core_clk(core_clk), .slow(slow), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic push_hex(logic [31:0] v);
    for (int i = 7; i >= 0; i--) e.push_back(v[i*4+:4] < 4'hA ? 8'h30 + v[i*4+:4] : 8'h37 + v[i*4+:4]);
  endtask
  task automatic push_dec(int v);
    for (int p = 10000; p > 0; p /= 10) e.push_back(8'h30 + 8'((v / p) % 10));
  endtask
  function automatic logic [3:0] hex_nib(logic [7:0] c);
    return (c >= 8'h41) ? 4'(c - 8'h37) : 4'(c - 8'h30);
  endfunction
  // one request, then compare the whole reply against e
  task automatic query(prf_query_t k, logic [3:0] u);
    int n;
    u_prf_host.rx_q.delete();
    @(negedge core_clk);
    req = '{k, u};
    req_valid = 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (!req_ready && n < 50);
    if (!req_ready) miscompares++;
    @(negedge core_clk);
    req_valid = 1'b0;
    while (u_prf_host.rx_q.size() < e.size() && n < 300) begin @(negedge core_clk); n++; end
    if (n >= 300) begin
      miscompares++;
      e.delete();
      return;
    end
    repeat (6) @(negedge core_clk);
    chk(32'(u_prf_host.rx_q.size()), 32'(e.size()));
    foreach (e[i]) chk(32'(u_prf_host.rx_q[i]), 32'(e[i]));
    e.delete();
  endtask
  task automatic t_bin;
    logic [31:0] v[2] = '{32'h000061A8, 32'hFFFF9E58};
    foreach (v[i]) begin
      move_steps = v[i];
      e = '{v[i][31:24], v[i][23:16], v[i][15:8], v[i][7:0]};
      query(PRF_Q_BIN, unit_number);
    end
    $display("t_bin done");
  endtask
  task automatic t_uhex;
    logic [31:0] v[2] = '{32'h01234567, 32'h89ABCDEF};
    foreach (v[i]) begin
      move_steps = v[i];
      push_hex(v[i]);
      query(PRF_Q_UHEX, unit_number);
    end
    $display("t_uhex done");
  endtask
  task automatic t_shex;
    logic [31:0] w;
    slow = 1'b1;
    move_steps = 32'hFFFF9E58;
    e.push_back(8'h2A);
    push_hex(move_steps);
    e.push_back(8'h0D);
    query(PRF_Q_SHEX, unit_number);
    slow = 1'b0;
    // host recovers the signed count from the eight received digits
    w = 32'h0;
    for (int i = 1; i <= 8; i++) w = {w[27:0], hex_nib(u_prf_host.rx_q[i])};
    chk(32'(u_prf_host.signed_value(w) == -64'sd25000), 32'h1);
    $display("t_shex done");
  endtask
  // reset in the middle of a reply, then a clean reply
  task automatic t_rst;
    move_steps = 32'h12345678;
    @(negedge core_clk);
    req = '{PRF_Q_BIN, unit_number};
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    chk(32'(req_ready), 32'h0);
    @(negedge core_clk);
    sys_rst = 1'b1;
    @(negedge core_clk);
    chk(32'(tx_valid), 32'h0);
    chk(32'(req_ready), 32'h1);
    sys_rst = 1'b0;
    e = '{8'h12, 8'h34, 8'h56, 8'h78};
    query(PRF_Q_BIN, unit_number);
    $display("t_rst done");
  endtask
  task automatic t_cks;
    int v[3] = '{149, 149, 65535};
    foreach (v[i]) begin
      seq_checksum = 16'(v[i]);
      e.push_back(8'h2A);
      push_dec(v[i]);
      query(PRF_Q_CKS, unit_number);
    end
    $display("t_cks done");
  endtask
  task automatic t_addr;
    move_steps = 32'h00FA0400;
    query(PRF_Q_BIN, 4'h5);
    e = '{8'h00, 8'hFA, 8'h04, 8'h00};
    query(PRF_Q_BIN, 4'h0);
    query(PRF_Q_NONE, unit_number);
    $display("t_addr done");
  endtask
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '{PRF_Q_NONE, 4'h0};
    slow = 1'b0;
    unit_number = 4'h3;
    move_steps = 32'h0;
    seq_checksum = 16'h0;
    repeat (10) @(negedge core_clk);
    sys_rst = 1'b0;
    t_bin();
    t_uhex();
    t_shex();
    t_cks();
    t_addr();
    t_rst();
    final_report();
  end
endmodule

// ---- prf_defs.svh ----
// constants for the position report formatter
`ifndef PRF_DEFS_SVH
`define PRF_DEFS_SVH
`define PRF_CHAR_STAR   8'h2A
`define PRF_CHAR_CR     8'h0D
`define PRF_CHAR_ZERO   8'h30
`define PRF_CHAR_A_M10  8'h37
`define PRF_HEX_DIGITS  4'h8
`define PRF_BIN_BYTES   4'h4
`define PRF_DEC_DIGITS  4'h5
`define PRF_CKS_MOD     17'h186A0
`endif

// ---- prf_formatter.sv ----
// position report formatter: answers position and checksum queries
// What this block does
// RULE_01: binary query returns four raw bytes
// RULE_02: binary bytes sent high byte first
// RULE_03: unsigned hex sends eight digits, MSD first
// RULE_04: unsigned hex carries no direction sign
// RULE_05: hex reports move-relative steps, answerable while moving
// RULE_06: digits encoded 0-9 then A-F
// RULE_07: signed hex starts with asterisk, eight digits
// RULE_08: carriage return right after eighth digit
// RULE_09: leading digit 8 or more means negative
// RULE_10: host subtracts 2^32 for negative values
// RULE_11: checksum query answers asterisk and five digits
// RULE_12: checksum stable until memory reprogrammed
// RULE_13: binary holds current or previous move distance
// RULE_14: binary report has no leading asterisk
// RULE_15: answer only queries addressed to this unit; unaddressed queries (unit 0) are answered too
module prf_formatter import prf_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire prf_req_t    req,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [3:0]  unit_number,
  input  wire logic [31:0] move_steps,
  input  wire logic [15:0] seq_checksum,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready
);
`include "prf_defs.svh"

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'hA) ? `PRF_CHAR_ZERO + {4'h0, nib}
                            : `PRF_CHAR_A_M10 + {4'h0, nib}; // RULE_06
  endfunction

  // five decimal digits packed as BCD, msd in the top nibble
  function automatic logic [31:0] to_bcd5(input logic [15:0] v);
    logic [16:0] r;
    logic [31:0] b;
    r = {1'b0, v} % `PRF_CKS_MOD;
    b = 32'h0;
    for (int i = 0; i < 5; i++) begin
      b = {4'h0, b[31:4]};
      b[19:16] = 4'(r % 17'd10);
      r = r / 17'd10;
    end
    to_bcd5 = {b[19:0], 12'h0};
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  prf_regs_t r, next_r;
  logic      hit;
  logic      take;

  // unaddressed queries (unit 0) are taken by every unit
  assign hit = (req.unit == unit_number) || (req.unit == 4'h0); // RULE_15
  // taken only while ready, so a refused request cannot slip in on the idle cycle
  assign take = req_valid && req_ready && hit && (req.kind != PRF_Q_NONE); // RULE_15
  assign req_ready = !r.busy;
  assign tx_data   = r.tx_data;
  assign tx_valid  = r.tx_valid;

  always_comb begin
    next_r = r;
    if (r.tx_valid && tx_ready) begin
      next_r.tx_valid = 1'b0;
    end
    unique case (r.state)
      PRF_S_IDLE: begin
        next_r.busy = 1'b0;
        if (take) begin
          next_r.busy = 1'b1;
          next_r.kind = req.kind;
          // snapshot live counter so a moving motor answers at once
          next_r.word = (req.kind == PRF_Q_CKS) ? to_bcd5(seq_checksum)
                                                : move_steps; // RULE_05 RULE_13 RULE_12
          unique case (req.kind)
            PRF_Q_BIN: begin
              next_r.state = PRF_S_BODY; // RULE_14
              next_r.left  = `PRF_BIN_BYTES; // RULE_01
            end
            PRF_Q_UHEX: begin
              next_r.state = PRF_S_BODY; // RULE_04
              next_r.left  = `PRF_HEX_DIGITS; // RULE_03
            end
            PRF_Q_SHEX: begin
              next_r.state = PRF_S_STAR; // RULE_07
              next_r.left  = `PRF_HEX_DIGITS;
            end
            default: begin
              next_r.state = PRF_S_STAR; // RULE_11
              next_r.left  = `PRF_DEC_DIGITS;
            end
          endcase
        end
      end
      PRF_S_STAR: begin
        if (!r.tx_valid || tx_ready) begin
          next_r.tx_data  = `PRF_CHAR_STAR; // RULE_07 RULE_11
          next_r.tx_valid = 1'b1;
          next_r.state    = PRF_S_BODY;
        end
      end
      PRF_S_BODY: begin
        if (!r.tx_valid || tx_ready) begin
          next_r.tx_valid = 1'b1;
          next_r.left     = r.left - 4'h1;
          if (r.kind == PRF_Q_BIN) begin
            next_r.tx_data = r.word[31:24]; // RULE_01 RULE_02
            next_r.word    = {r.word[23:0], 8'h00};
          end else begin
            // two's complement kept as is, so top digit >= 8 is negative
            next_r.tx_data = hex_char(r.word[31:28]); // RULE_03 RULE_09
            next_r.word    = {r.word[27:0], 4'h0};
          end
          if (r.left == 4'h1) begin
            next_r.state = (r.kind == PRF_Q_SHEX) ? PRF_S_CR : PRF_S_IDLE;
          end
        end
      end
      PRF_S_CR: begin
        if (!r.tx_valid || tx_ready) begin
          next_r.tx_data  = `PRF_CHAR_CR; // RULE_08
          next_r.tx_valid = 1'b1;
          next_r.state    = PRF_S_IDLE;
        end
      end
      default: next_r.state = PRF_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{state: PRF_S_IDLE, kind: PRF_Q_NONE, word: 32'h0, left: 4'h0,
             tx_data: 8'h00, tx_valid: 1'b0, busy: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_cr_after_digit;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_CR && tx_valid && tx_ready) |=> (tx_data == 8'h0D);
  endproperty
  a_cr_after_digit: assert property (p_cr_after_digit) else $error("cr missing"); // RULE_08

  property p_star_first;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_IDLE && take && req.kind == PRF_Q_SHEX && !tx_valid)
        |=> (r.state == PRF_S_STAR) ##1 (tx_data == 8'h2A);
  endproperty
  a_star_first: assert property (p_star_first) else $error("no asterisk"); // RULE_07

  property p_bin_no_star;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_IDLE && take && req.kind == PRF_Q_BIN)
        |=> (r.state == PRF_S_BODY && r.left == 4'h4);
  endproperty
  a_bin_no_star: assert property (p_bin_no_star) else $error("binary start wrong"); // RULE_14

  property p_hex_chars;
    @(posedge core_clk) disable iff (sys_rst)
      (tx_valid && (r.kind == PRF_Q_UHEX || r.kind == PRF_Q_SHEX) && r.state == PRF_S_BODY
       && r.left != 4'h8)
        |-> ((tx_data >= 8'h30 && tx_data <= 8'h39) || (tx_data >= 8'h41 && tx_data <= 8'h46));
  endproperty
  a_hex_chars: assert property (p_hex_chars) else $error("bad hex char"); // RULE_06

  property p_unaddressed;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_IDLE && req_valid && !hit) |=> (r.state == PRF_S_IDLE);
  endproperty
  a_unaddressed: assert property (p_unaddressed) else $error("answered other unit"); // RULE_15

  property p_bin_first_byte;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_IDLE && take && req.kind == PRF_Q_BIN && !tx_valid)
        |=> ##1 (tx_data == $past(move_steps, 2) >> 24);
  endproperty
  a_bin_first_byte: assert property (p_bin_first_byte) else $error("msb not first"); // RULE_02

  property p_uhex_len;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_IDLE && take && req.kind == PRF_Q_UHEX)
        |=> (r.left == 4'h8 && r.state == PRF_S_BODY);
  endproperty
  a_uhex_len: assert property (p_uhex_len) else $error("hex length wrong"); // RULE_03

  property p_cks_len;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_IDLE && take && req.kind == PRF_Q_CKS)
        |=> (r.left == 4'h5 && r.state == PRF_S_STAR);
  endproperty
  a_cks_len: assert property (p_cks_len) else $error("checksum length wrong"); // RULE_11

  property p_tx_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data));
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("byte changed before taken"); // RULE_01

  property p_shex_cr_next;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_BODY && r.kind == PRF_Q_SHEX && r.left == 4'h1
       && (!tx_valid || tx_ready)) |=> (r.state == PRF_S_CR);
  endproperty
  a_shex_cr_next: assert property (p_shex_cr_next) else $error("cr not next"); // RULE_08

  property p_bin_four;
    @(posedge core_clk) disable iff (sys_rst)
      (r.state == PRF_S_BODY && r.kind == PRF_Q_BIN && r.left == 4'h1
       && (!tx_valid || tx_ready)) |=> (r.state == PRF_S_IDLE);
  endproperty
  a_bin_four: assert property (p_bin_four) else $error("binary length wrong"); // RULE_01

  property p_cks_digits;
    @(posedge core_clk) disable iff (sys_rst)
      (tx_valid && r.kind == PRF_Q_CKS && r.state == PRF_S_BODY && r.left != 4'h5)
        |-> (tx_data >= 8'h30 && tx_data <= 8'h39);
  endproperty
  a_cks_digits: assert property (p_cks_digits) else $error("checksum digit not decimal"); // RULE_11
endmodule

// ---- prf_host.sv ----
// host model on the far side of the reply stream
module prf_host (
  input  wire logic       core_clk,
  input  wire logic       slow,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  // slow host toggles ready, so every byte must stand until taken
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) rx_q.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // signed recovery: leading digit 8 or above means negative
  function automatic longint signed_value(logic [31:0] u);
    return u[31] ? longint'(u) - 64'sd4294967296 : longint'(u);
  endfunction
endmodule

// ---- prf_pkg.sv ----
// types for the position report formatter
package prf_pkg;
  typedef enum logic [2:0] {
    PRF_Q_NONE,
    PRF_Q_BIN,
    PRF_Q_UHEX,
    PRF_Q_SHEX,
    PRF_Q_CKS
  } prf_query_t;

  typedef enum logic [2:0] {
    PRF_S_IDLE,
    PRF_S_STAR,
    PRF_S_BODY,
    PRF_S_CR
  } prf_state_t;

  typedef struct packed {
    prf_query_t kind;
    logic [3:0] unit;
  } prf_req_t;

  typedef struct packed {
    prf_state_t  state;
    prf_query_t  kind;
    logic [31:0] word;
    logic [3:0]  left;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        busy;
  } prf_regs_t;
endpackage
